// ---- hdl/ulps_link_power_regs.sv ----
// Purpose: Link power status registers, exit latencies and PHY defaults
// Assumes: Request decoder delivers one-cycle pulses; inputs synchronous to sys_clk
// Notes:   Register port answers reads one cycle later, never stalls
//
// What this block does
// - PHY fields default EEPROM, else OTP, else zero
// - USB or lite reset restores last image
// - Swing field from config flags swing bit
// - Margin field from config flags margin bit
// - Emphasis field from config flags emphasis bit
// - Elastic buffer mode from config flags bit
// - Shallow device-to-host latency at bits 23:16
// - Shallow system latency at bits 7:0
// - Deep device-to-host latency at bits 31:16
// - Deep system latency at bits 15:0
// - Latencies load only from SET_SEL, read-only
// - Low status flags drive status-change interrupt bit
// - Current states mirrored at bits 20:16 of the upper half
// - SET_SEL sets bit 5, updates latencies
// - Bits 4..0 flag host changes of states
// - Bits 20..16 show current states, read-only
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "ulps_cfg.svh"

module ulps_link_power_regs
  import ulps_pkg::*;
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic [`ULPS_ADDR_W-1:0]   regAddr,
  input  wire logic [31:0]               regWdata,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [31:0]               regRdata,
  input  wire logic                      setSelReq,
  input  wire ulps_latency_type          setSelData,
  input  wire logic                      setFeatureReq,
  input  wire ulps_state_type            setFeatureData,
  input  wire logic                      usbReset,
  input  wire logic                      liteSoftReset,
  input  wire logic                      eepromLoad,
  input  wire logic                      eepromPresent,
  input  wire logic [7:0]                eepromCfgFlags1,
  input  wire logic                      otpLoad,
  input  wire logic                      otpProgrammed,
  input  wire logic [7:0]                otpCfgFlags1,
  output ulps_phy_type                   phyCfg,
  output logic                           linkStatusIrqBit,
  output logic                           irq
);

  typedef struct packed {
    ulps_latency_type             latency;
    ulps_state_type               current;
    logic [`ULPS_FLAG_W-1:0]      irqMask;
    logic [31:0]                  rdata;
    logic                         statusBit;
    logic                         irqLine;
    ulps_phy_type                 phyOut;
  } ulps_regst_type;

  ulps_regst_type           state;
  ulps_regst_type           next_state;
  ulps_bus_type             bus;
  logic [`ULPS_FLAG_W-1:0]  flags;
  logic [`ULPS_FLAG_W-1:0]  setEvent;
  logic [`ULPS_FLAG_W-1:0]  clearMask;
  logic                     phyWrite;
  ulps_phy_type             phyLive;

  function automatic logic hit(input ulps_bus_type b, input logic [`ULPS_ADDR_W-1:0] ofs);
    return b.addr == ofs;
  endfunction

  assign bus = '{write: regWrite, read: regRead, addr: regAddr, wdata: regWdata};

  // Change events: host modified a tracked state, or delivered SET_SEL
  always_comb begin
    setEvent = '0;
    setEvent[`ULPS_SEL_BIT] = setSelReq;
    if (setFeatureReq) begin
      setEvent[`ULPS_STATE_W-1:0] = setFeatureData ^ state.current;
    end
    clearMask = (bus.write && hit(bus, `ULPS_OFS_STATUS)) ?
                bus.wdata[`ULPS_FLAG_W-1:0] : '0;
    phyWrite = bus.write && hit(bus, `ULPS_OFS_PHY_CFG);
  end

  ulps_change_flags #(
    .FLAG_W (`ULPS_FLAG_W)
  ) u_flags (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .setEvent  (setEvent),
    .clearMask (clearMask),
    .flags     (flags)
  );

  ulps_phy_defaults u_phy (
    .sys_clk         (sys_clk),
    .rst_n           (rst_n),
    .eepromLoad      (eepromLoad),
    .eepromPresent   (eepromPresent),
    .eepromCfgFlags1 (eepromCfgFlags1),
    .otpLoad         (otpLoad),
    .otpProgrammed   (otpProgrammed),
    .otpCfgFlags1    (otpCfgFlags1),
    .restore         (usbReset || liteSoftReset),
    .swWrite         (phyWrite),
    .swValue         (ulps_phy_type'(bus.wdata[3:0])),
    .phyCfg          (phyLive)
  );

  always_comb begin
    next_state = state;
    // Latencies change only through SET_SEL; register writes ignored
    if (setSelReq) begin
      next_state.latency = setSelData;
    end
    if (setFeatureReq) begin
      next_state.current = setFeatureData;
    end
    if (bus.write && hit(bus, `ULPS_OFS_IRQ_MASK)) begin
      next_state.irqMask = bus.wdata[`ULPS_FLAG_W-1:0];
    end
    next_state.rdata = '0;
    if (bus.read) begin
      unique case (bus.addr)
        `ULPS_OFS_SHALLOW: begin
          next_state.rdata[`ULPS_SHALLOW_D2H_LSB +: 8] =
            state.latency.shallowDevToHostLatency;
          next_state.rdata[`ULPS_SHALLOW_SYS_LSB +: 8] =
            state.latency.shallowSystemLatency;
        end
        `ULPS_OFS_DEEP: begin
          next_state.rdata[`ULPS_DEEP_D2H_LSB +: 16] =
            state.latency.deepDevToHostLatency;
          next_state.rdata[`ULPS_DEEP_SYS_LSB +: 16] =
            state.latency.deepSystemLatency;
        end
        `ULPS_OFS_STATUS: begin
          next_state.rdata[`ULPS_FLAG_W-1:0] = flags;
          next_state.rdata[`ULPS_STATE_LSB +: `ULPS_STATE_W] = state.current;
        end
        `ULPS_OFS_IRQ_MASK: begin
          next_state.rdata[`ULPS_FLAG_W-1:0] = state.irqMask;
        end
        `ULPS_OFS_PHY_CFG: begin
          next_state.rdata[3:0] = phyLive;
        end
        default: begin
          next_state.rdata = '0;
        end
      endcase
    end
    next_state.statusBit = |flags;
    next_state.irqLine   = |(flags & state.irqMask);
    next_state.phyOut    = phyLive;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.latency   <= '{`ULPS_LAT_RESET, `ULPS_LAT_RESET,
                           `ULPS_LAT16_RESET, `ULPS_LAT16_RESET};
      state.current   <= `ULPS_STATE_RESET;
      state.irqMask   <= `ULPS_FLAG_RESET;
      state.rdata     <= '0;
      state.statusBit <= 1'b0;
      state.irqLine   <= 1'b0;
      state.phyOut    <= `ULPS_PHY_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign regRdata         = state.rdata;
  assign linkStatusIrqBit = state.statusBit;
  assign irq              = state.irqLine;
  assign phyCfg           = state.phyOut;

endmodule
`default_nettype wire

// ---- hdl/ulps_cfg.svh ----
// Purpose: Offsets, field positions, reset values for the link power status bank
// Assumes: 32-bit register port, byte addresses
// Notes:   Shared by the register, PHY default and change flag modules
`ifndef ULPS_CFG_SVH
`define ULPS_CFG_SVH

`define ULPS_ADDR_W          8
`define ULPS_OFS_SHALLOW     8'hA0
`define ULPS_OFS_DEEP        8'hA4
`define ULPS_OFS_STATUS      8'hA8
`define ULPS_OFS_IRQ_MASK    8'hAC
`define ULPS_OFS_PHY_CFG     8'hB8
`define ULPS_SHALLOW_D2H_LSB 16
`define ULPS_SHALLOW_SYS_LSB 0
`define ULPS_DEEP_D2H_LSB    16
`define ULPS_DEEP_SYS_LSB    0
`define ULPS_STATE_LSB       16
`define ULPS_SEL_BIT         5
`define ULPS_FLAG_W          6
`define ULPS_STATE_W         5
`define ULPS_CFGFLAG_SWING   0
`define ULPS_CFGFLAG_MARGIN  1
`define ULPS_CFGFLAG_EMPH    2
`define ULPS_CFGFLAG_EBUF    3
`define ULPS_LAT_RESET       8'h00
`define ULPS_LAT16_RESET     16'h0000
`define ULPS_STATE_RESET     5'h00
`define ULPS_FLAG_RESET      6'h00
`define ULPS_PHY_RESET       4'h0

`endif

// ---- hdl/ulps_pkg.sv ----
// Purpose: Types of the link power status bank
// Assumes: Constants come from ulps_cfg.svh
// Notes:   Types only
package ulps_pkg;

  // Order matches status bits 4..0: devWake, funcWake, ltm, deep, shallow
  typedef struct packed {
    logic deviceWakeState;
    logic functionWakeState;
    logic latencyMsgEnState;
    logic deepLpmEnState;
    logic shallowLpmEnState;
  } ulps_state_type;

  typedef struct packed {
    logic [7:0]  shallowDevToHostLatency;
    logic [7:0]  shallowSystemLatency;
    logic [15:0] deepDevToHostLatency;
    logic [15:0] deepSystemLatency;
  } ulps_latency_type;

  typedef struct packed {
    logic phyElasticBufMode;
    logic phyTxEmphasisSel;
    logic phyTxMarginSel;
    logic phyTxSwingSel;
  } ulps_phy_type;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [31:0] wdata;
  } ulps_bus_type;

  typedef enum logic [1:0] {
    ULPS_SRC_NONE,
    ULPS_SRC_OTP,
    ULPS_SRC_EEPROM
  } ulps_src_type;

endpackage

// ---- hdl/ulps_phy_defaults.sv ----
// Purpose: Holds the PHY configuration image and restores the four PHY fields
// Assumes: Loader presents each image once with a one-cycle strobe
// Notes:   EEPROM image wins over OTP; none yields zero
`timescale 1ns/100ps
`default_nettype none
`include "ulps_cfg.svh"

module ulps_phy_defaults
  import ulps_pkg::*;
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         eepromLoad,
  input  wire logic         eepromPresent,
  input  wire logic [7:0]   eepromCfgFlags1,
  input  wire logic         otpLoad,
  input  wire logic         otpProgrammed,
  input  wire logic [7:0]   otpCfgFlags1,
  input  wire logic         restore,
  input  wire logic         swWrite,
  input  wire ulps_phy_type swValue,
  output ulps_phy_type      phyCfg
);

  typedef struct packed {
    ulps_phy_type image;
    ulps_src_type source;
    ulps_phy_type live;
  } ulps_physt_type;

  ulps_physt_type state;
  ulps_physt_type next_state;

  function automatic ulps_phy_type fromFlags(input logic [7:0] flags);
    ulps_phy_type p;
    p.phyTxSwingSel     = flags[`ULPS_CFGFLAG_SWING];
    p.phyTxMarginSel    = flags[`ULPS_CFGFLAG_MARGIN];
    p.phyTxEmphasisSel  = flags[`ULPS_CFGFLAG_EMPH];
    p.phyElasticBufMode = flags[`ULPS_CFGFLAG_EBUF];
    return p;
  endfunction

  always_comb begin
    next_state = state;
    // EEPROM image outranks OTP; unprogrammed sources leave zero
    if (eepromLoad && eepromPresent) begin
      next_state.image  = fromFlags(eepromCfgFlags1);
      next_state.source = ULPS_SRC_EEPROM;
      next_state.live   = fromFlags(eepromCfgFlags1);
    end else if (otpLoad && otpProgrammed && state.source != ULPS_SRC_EEPROM) begin
      next_state.image  = fromFlags(otpCfgFlags1);
      next_state.source = ULPS_SRC_OTP;
      next_state.live   = fromFlags(otpCfgFlags1);
    end else if (restore) begin
      next_state.live = (state.source == ULPS_SRC_NONE) ? ulps_phy_type'(`ULPS_PHY_RESET)
                                                        : state.image;
    end else if (swWrite) begin
      next_state.live = swValue;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '{image: `ULPS_PHY_RESET, source: ULPS_SRC_NONE, live: `ULPS_PHY_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign phyCfg = state.live;

endmodule
`default_nettype wire

// ---- hdl/ulps_change_flags.sv ----
// Purpose: Sticky change flags with write-one-to-clear
// Assumes: Events are one-cycle pulses
// Notes:   A set in the clearing cycle wins
`timescale 1ns/100ps
`default_nettype none
`include "ulps_cfg.svh"

module ulps_change_flags
  import ulps_pkg::*;
#(
  parameter int FLAG_W = `ULPS_FLAG_W
)
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [FLAG_W-1:0] setEvent,
  input  wire logic [FLAG_W-1:0] clearMask,
  output logic      [FLAG_W-1:0] flags
);

  // Flags live in the low half of the status word
  if (FLAG_W < 1 || FLAG_W > 16) begin : g_bad_width
    $error("FLAG_W must be 1..16");
  end

  typedef struct packed {
    logic [FLAG_W-1:0] bits;
  } ulps_flagst_type;

  ulps_flagst_type state;
  ulps_flagst_type next_state;

  always_comb begin
    next_state.bits = (state.bits & ~clearMask) | setEvent;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.bits <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flags = state.bits;

endmodule
`default_nettype wire

// ---- bench/ulps_regs_properties.sv ----
// Purpose: Port properties of the link power status bank
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to the top module
`timescale 1ns/100ps
`default_nettype none
module ulps_regs_props
  import ulps_pkg::*;
(
  input wire logic         sys_clk,
  input wire logic         rst_n,
  input wire logic [7:0]   regAddr,
  input wire logic         regWrite,
  input wire logic         regRead,
  input wire logic [31:0]  regRdata,
  input wire logic         setSelReq,
  input wire logic         eepromLoad,
  input wire logic         eepromPresent,
  input wire logic [7:0]   eepromCfgFlags1,
  input wire ulps_phy_type phyCfg,
  input wire logic         linkStatusIrqBit,
  input wire logic         irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_selFlag; setSelReq |-> ##2 linkStatusIrqBit; endproperty
  a_selFlag: assert property (p_selFlag) else $error("no flag");
  property p_selRd;
    setSelReq ##1 !regWrite ##1 (regRead && regAddr == 8'hA8) |=> regRdata[5];
  endproperty
  a_selRd: assert property (p_selRd) else $error("no bit 5");
  property p_latRd;
    $past(regRead && regAddr == 8'hA0) |-> regRdata[31:24] == 8'h00 && regRdata[15:8] == 8'h00;
  endproperty
  a_latRd: assert property (p_latRd) else $error("gap bits set");
  property p_stsRd;
    $past(regRead && regAddr == 8'hA8) |-> regRdata[31:21] == 11'h0 && regRdata[15:6] == 10'h0;
  endproperty
  a_stsRd: assert property (p_stsRd) else $error("gap bits set");
  property p_rdIrq;
    $past(regRead && regAddr == 8'hA8) |-> linkStatusIrqBit == (|regRdata[5:0]);
  endproperty
  a_rdIrq: assert property (p_rdIrq) else $error("flag mismatch");
  property p_hold; linkStatusIrqBit && !$past(regWrite) |=> linkStatusIrqBit; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
  property p_mask; irq |-> linkStatusIrqBit; endproperty
  a_mask: assert property (p_mask) else $error("irq without flag");
  property p_ee;
    eepromLoad && eepromPresent ##2 1'b1 |-> phyCfg == $past(eepromCfgFlags1[3:0], 2);
  endproperty
  a_ee: assert property (p_ee) else $error("phy image");
  c_sel: cover property (setSelReq);
  c_irq: cover property (irq);
  c_ee: cover property (eepromLoad && eepromPresent);
endmodule
bind ulps_link_power_regs ulps_regs_props chk_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regRdata(regRdata), .setSelReq(setSelReq), .eepromLoad(eepromLoad),
  .eepromPresent(eepromPresent), .eepromCfgFlags1(eepromCfgFlags1), .phyCfg(phyCfg),
  .linkStatusIrqBit(linkStatusIrqBit), .irq(irq)
);
`default_nettype wire

// ---- bench/ulps_host_model.sv ----
// Purpose: Host side issuing select, feature and bus reset requests
// Assumes: Calls start right after an edge
// Notes:   Released data lines show the inverse
`timescale 1ns/100ps
`default_nettype none
module ulps_host_model
  import ulps_pkg::*;
(
  input  wire logic             sys_clk,
  output var  logic             setSelReq,
  output var  ulps_latency_type setSelData,
  output var  logic             setFeatureReq,
  output var  ulps_state_type   setFeatureData,
  output var  logic             usbReset
);
  initial begin
    {setSelReq, setFeatureReq, usbReset} = 3'h0;
    setSelData = '0;
    setFeatureData = '0;
  end
  task automatic sel(input ulps_latency_type d);
    @(posedge sys_clk);
    setSelReq <= 1'b1;
    setSelData <= d;
    @(posedge sys_clk);
    setSelReq <= 1'b0;
    setSelData <= ~d;
  endtask
  task automatic feat(input ulps_state_type d);
    @(posedge sys_clk);
    setFeatureReq <= 1'b1;
    setFeatureData <= d;
    @(posedge sys_clk);
    setFeatureReq <= 1'b0;
    setFeatureData <= ~d;
  endtask
  task automatic busReset;
    @(posedge sys_clk);
    usbReset <= 1'b1;
    @(posedge sys_clk);
    usbReset <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/ulps_link_power_regs_tb.sv ----
// Purpose: Self-checking bench of the link power status bank
// Assumes: Read data stand one cycle after the strobe
// Notes:   Host requests come from the host model
`timescale 1ns/100ps
`default_nettype none
module ulps_link_power_regs_tb import ulps_pkg::*;;
  logic             sys_clk, rst_n, regWrite, regRead, setSelReq, setFeatureReq, usbReset;
  logic             liteSoftReset, eepromLoad, eepromPresent, otpLoad, otpProgrammed;
  logic             linkStatusIrqBit, irq;
  logic [7:0]       regAddr, eepromCfgFlags1, otpCfgFlags1;
  logic [31:0]      regWdata, regRdata;
  ulps_latency_type setSelData;
  ulps_state_type   setFeatureData;
  ulps_phy_type     phyCfg;
  int               errorCnt = 0;
  int               samplesChecked = 0;
  ulps_link_power_regs dut_u (
    .sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .setSelReq(setSelReq),
    .setSelData(setSelData), .setFeatureReq(setFeatureReq), .setFeatureData(setFeatureData),
    .usbReset(usbReset), .liteSoftReset(liteSoftReset), .eepromLoad(eepromLoad),
    .eepromPresent(eepromPresent), .eepromCfgFlags1(eepromCfgFlags1), .otpLoad(otpLoad),
    .otpProgrammed(otpProgrammed), .otpCfgFlags1(otpCfgFlags1), .phyCfg(phyCfg),
    .linkStatusIrqBit(linkStatusIrqBit), .irq(irq));
  ulps_host_model host_u (
    .sys_clk(sys_clk), .setSelReq(setSelReq), .setSelData(setSelData),
    .setFeatureReq(setFeatureReq), .setFeatureData(setFeatureData), .usbReset(usbReset));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 chk(regRdata, exp);
  endtask
  task automatic nv(input logic ee, input logic ok, input logic [7:0] f);
    @(posedge sys_clk);
    eepromLoad <= ee;
    otpLoad <= !ee;
    eepromPresent <= ok;
    otpProgrammed <= ok;
    eepromCfgFlags1 <= f;
    otpCfgFlags1 <= f;
    @(posedge sys_clk);
    eepromLoad <= 1'b0;
    otpLoad <= 1'b0;
  endtask
  // Registered outputs land one edge later
  task automatic phy(input logic [3:0] exp);
    @(posedge sys_clk);
    #1 chk({28'h0, phyCfg}, {28'h0, exp});
  endtask
  task automatic completeRun;
    $display("errors %0d checks %0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk);
    errorCnt++;
    completeRun;
  end
  initial begin
    logic [4:0] st;
    logic [4:0] prev;
    prev = 5'h00;
    rst_n = 1'b0;
    {regWrite, regRead, liteSoftReset, eepromLoad, eepromPresent, otpLoad} = 6'h00;
    otpProgrammed = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0;
    eepromCfgFlags1 = 8'h00;
    otpCfgFlags1 = 8'h00;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(8'hA0, 32'h0);
    rd(8'hA8, 32'h0);
    host_u.sel({8'h12, 8'h34, 16'hABCD, 16'h5678});
    rd(8'hA8, 32'h20);
    rd(8'hA0, 32'h0012_0034);
    rd(8'hA4, 32'hABCD_5678);
    chk({31'h0, irq}, 32'h0);
    wr(8'hA4, 32'hFFFF_FFFF);
    rd(8'hA4, 32'hABCD_5678);
    wr(8'hA8, 32'h0);
    rd(8'hA8, 32'h20);
    wr(8'hAC, 32'h20);
    phy(4'h0);
    chk({31'h0, irq}, 32'h1);
    wr(8'hA8, 32'h20);
    phy(4'h0);
    chk({31'h0, linkStatusIrqBit}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      st = 5'h01 << i;
      host_u.feat(st);
      rd(8'hA8, {11'h0, st, 11'h0, st ^ prev});
      wr(8'hA8, 32'h1F);
      prev = st;
    end
    wr(8'hA8, 32'hFFFF_0000);
    host_u.feat(prev);
    rd(8'hA8, {11'h0, prev, 16'h0});
    rd(8'h10, 32'h0);
    nv(1'b0, 1'b0, 8'h0F);
    phy(4'h0);
    nv(1'b0, 1'b1, 8'h05);
    phy(4'h5);
    wr(8'hB8, 32'hF);
    phy(4'hF);
    host_u.busReset();
    phy(4'h5);
    nv(1'b1, 1'b1, 8'hFA);
    phy(4'hA);
    nv(1'b0, 1'b1, 8'h03);
    phy(4'hA);
    wr(8'hB8, 32'h0);
    @(posedge sys_clk);
    liteSoftReset <= 1'b1;
    @(posedge sys_clk);
    liteSoftReset <= 1'b0;
    phy(4'hA);
    completeRun;
  end
endmodule
`default_nettype wire
